// ==== core/cls_map.svh ====
/*
  Register offsets, field positions, reset values and response codes
  of the configurable logic block. Assumes a 32-bit AXI4-Lite slave
  with an 8-bit byte address.
*/
`ifndef CLS_MAP_SVH
`define CLS_MAP_SVH

////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses)
`define CLS_ADDR_W 8
`define CLS_OFF_CTRL 8'h00
`define CLS_OFF_STAT 8'h04
`define CLS_OFF_CFG 8'h10
`define CLS_OFF_TBL 8'h20

////////////////////////////////////////////////////////////////////////
// Control register fields and reset
`define CLS_CTRL_USER 0
`define CLS_CTRL_NORAM 1
`define CLS_CTRL_RST 2'h0

////////////////////////////////////////////////////////////////////////
// Slice configuration fields and reset
`define CLS_CFG_MODE_LSB 0
`define CLS_CFG_MODE_MSB 1
`define CLS_CFG_OP_LSB 2
`define CLS_CFG_OP_MSB 4
`define CLS_CFG_FIVE_INPUT_TABLE 5
`define CLS_CFG_LATCH0 6
`define CLS_CFG_CLKNEG 8
`define CLS_CFG_LSRSYNC 9
`define CLS_CFG_INIT0 10
`define CLS_CFG_DPR 12
`define CLS_CFG_RST 16'h0000
`define CLS_TBL_RST 32'h0000_0000

////////////////////////////////////////////////////////////////////////
// Status register fields
`define CLS_STAT_Q_LSB 0
`define CLS_STAT_GEN_LSB 8
`define CLS_STAT_PROP_LSB 12
`define CLS_STAT_FCO 16
`define CLS_STAT_USER 17

////////////////////////////////////////////////////////////////////////
// Bus responses
`define CLS_RESP_OKAY 2'h0
`define CLS_RESP_SLVERR 2'h2

`endif

// ==== core/cls_pkg.sv ====
/*
  Types of the configurable logic block: modes, ripple operations,
  fabric and bus carriers, state records. Assumes nothing else.
*/
package cls_pkg;

  // Slice operating modes
  typedef enum logic [1:0] {
    MODE_LOGIC = 2'b00,
    MODE_RIPPLE = 2'b01,
    MODE_RAM = 2'b10,
    MODE_ROM = 2'b11
  } cls_mode_type;

  // Ripple mode operations
  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_SUB = 3'b001,
    OP_ADDSUB = 3'b010,
    OP_UPCNT = 3'b011,
    OP_DNCNT = 3'b100,
    OP_MULT = 3'b101,
    OP_CMP = 3'b110
  } cls_op_type;

  // Register decode result
  typedef enum logic [2:0] {
    SEL_CTRL = 3'b000,
    SEL_STAT = 3'b001,
    SEL_CFG = 3'b010,
    SEL_TBL = 3'b011,
    SEL_NONE = 3'b100
  } cls_sel_type;

  // Per-slice fabric inputs, 10 bits
  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] c;
    logic [1:0] d;
    logic [1:0] m;
  } cls_slice_in_type;

  // Block fabric inputs, 53 bits
  typedef struct packed {
    cls_slice_in_type [3:0] sl;
    logic clk;
    logic lsr;
    logic ce;
    logic wre;
    logic fci;
    logic [1:0] cs;
    logic [3:0] wad;
    logic [1:0] wd;
  } cls_fab_in_type;

  // Per-slice fabric outputs, 5 bits
  typedef struct packed {
    logic [1:0] f;
    logic [1:0] q;
    logic ofx;
  } cls_slice_out_type;

  // Block fabric outputs, 25 bits
  typedef struct packed {
    cls_slice_out_type [3:0] sl;
    logic fco;
    logic cg;
    logic cp;
    logic wide6;
    logic wide7;
  } cls_fab_out_type;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } cls_axi_req_type;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cls_axi_rsp_type;

  // State of the block
  typedef struct packed {
    logic [1:0] ctrl;
    logic [3:0][15:0] cfg;
    logic [3:0][1:0] q;
    logic clk_prev;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cls_state_type;

  // State of one 16x2 table
  typedef struct packed {
    logic [15:0] col1;
    logic [15:0] col0;
  } cls_mem_type;

endpackage

// ==== core/cls_ram16x2.sv ====
/*
  One slice's pair of 16-entry tables, usable as two 16x1 tables or
  as one 16x2 memory. Assumes loads and writes on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module cls_ram16x2 (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic load_en,
  input wire logic [31:0] load_data,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [1:0] wdata,
  input wire logic [3:0] raddr0,
  input wire logic [3:0] raddr1,
  output logic [1:0] rdata,
  output logic [31:0] contents
);
  import cls_pkg::*;

  cls_mem_type mem_q;
  cls_mem_type mem_d;

  // Table load has priority over a fabric write
  always_comb begin
    mem_d = mem_q;
    if (load_en) begin
      mem_d = load_data;
    end else if (we) begin
      mem_d.col0[waddr] = wdata[0];
      mem_d.col1[waddr] = wdata[1];
    end
  end

  // Storage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

  // Combinational read of both columns
  assign rdata = {mem_q.col1[raddr1], mem_q.col0[raddr0]};
  assign contents = mem_q;

endmodule // cls_ram16x2

`default_nettype wire

// ==== core/cls_logic_block.sv ====
/*
  Configurable logic block of four slices with tables, ripple
  arithmetic, distributed memory and storage elements, configured
  over AXI4-Lite. Assumes fabric inputs synchronous to sys_clk.
*/
// Contract
// - Two tables per slice feed flip-flop-or-latch elements
// - Set/reset selectable synchronous or asynchronous
// - Clock polarity and edge/level selectable
// - Four modes; RAM-less variant lacks RAM
// - Logic mode: any 4-input function, 16 entries
// - Tables combine to five inputs; slices chain wider
// - Ripple: add, sub, addsub, counters, multiply step
// - Ripple compare: ge, ne, le
// - Carry generate and propagate per slice
// - RAM: 16x2 single port in one slice
// - Dual port pairs slice with read-only companion
// - ROM: two 16x1 tables per slice
// - Entering user mode loads configured set/reset state
// - Four slices, 53 inputs, 25 outputs
`timescale 1ns/1ps
`default_nettype none
`include "cls_map.svh"

module cls_logic_block (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire cls_pkg::cls_axi_req_type axi_req,
  output var cls_pkg::cls_axi_rsp_type axi_rsp,
  input wire cls_pkg::cls_fab_in_type fab_in,
  output var cls_pkg::cls_fab_out_type fab_out
);
  import cls_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Table address from the four inputs of table i
  function automatic logic [3:0] tbl_addr(input cls_slice_in_type si, input int i);
    tbl_addr = {si.d[i], si.c[i], si.b[i], si.a[i]};
  endfunction

  // Two-bit add with carry, carry out on top
  function automatic logic [2:0] add2(input logic [1:0] x, input logic [1:0] y, input logic ci);
    add2 = {1'b0, x} + {1'b0, y} + {2'h0, ci};
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        merge[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
  endfunction

  // Register decode
  function automatic cls_sel_type reg_sel(input logic [7:0] adr);
    if (adr[1:0] != 2'h0) begin
      reg_sel = SEL_NONE;
    end else if (adr == `CLS_OFF_CTRL) begin
      reg_sel = SEL_CTRL;
    end else if (adr == `CLS_OFF_STAT) begin
      reg_sel = SEL_STAT;
    end else if ({adr[7:4], 4'h0} == `CLS_OFF_CFG) begin
      reg_sel = SEL_CFG;
    end else if ({adr[7:4], 4'h0} == `CLS_OFF_TBL) begin
      reg_sel = SEL_TBL;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Signals

  cls_state_type st_q;
  cls_state_type st_d;
  cls_mode_type mode [4];
  cls_op_type op [4];
  logic [3:0][3:0] raddr0;
  logic [3:0][3:0] raddr1;
  logic [3:0][1:0] rdat;
  logic [3:0][31:0] tbl;
  logic [3:0][1:0] ax;
  logic [3:0][1:0] bx;
  logic [3:0][2:0] sum;
  logic [3:0][1:0] fval;
  logic [3:0] we;
  logic [3:0] ld;
  logic [3:0] gen;
  logic [3:0] prop;
  logic [3:0] ne;
  logic [3:0] ofx;
  logic [4:0] carry;
  logic [31:0] ld_data;
  logic [31:0] stat;
  logic user;
  logic noram;
  logic wr_go;
  logic wide6b;
  cls_sel_type wsel;
  cls_sel_type rsel;

  assign user = st_q.ctrl[`CLS_CTRL_USER];
  assign noram = st_q.ctrl[`CLS_CTRL_NORAM];
  assign wr_go = st_q.aw_have & st_q.w_have & ~st_q.bvalid;
  assign wsel = reg_sel(st_q.awaddr);
  assign rsel = reg_sel(axi_req.araddr);
  assign ld_data = merge(tbl[st_q.awaddr[3:2]], st_q.wdata, st_q.wstrb);

  ////////////////////////////////////////////////////////////////////
  // Slice tables, one 16x2 memory per slice

  for (genvar s = 0; s < 4; s++) begin : g_slice
    cls_ram16x2 u_tbl (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .load_en(ld[s]),
      .load_data(ld_data),
      .we(we[s]),
      .waddr(fab_in.wad),
      .wdata(fab_in.wd),
      .raddr0(raddr0[s]),
      .raddr1(raddr1[s]),
      .rdata(rdat[s]),
      .contents(tbl[s])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Slice datapath: tables, ripple chain, memory write enables

  always_comb begin
    carry[0] = fab_in.fci;
    for (int s = 0; s < 4; s++) begin
      mode[s] = cls_mode_type'(st_q.cfg[s][`CLS_CFG_MODE_MSB:`CLS_CFG_MODE_LSB]);
      op[s] = cls_op_type'(st_q.cfg[s][`CLS_CFG_OP_MSB:`CLS_CFG_OP_LSB]);
      // Table addresses; RAM mode reads one 16x2 word
      raddr0[s] = tbl_addr(fab_in.sl[s], 0);
      if (mode[s] == MODE_RAM) begin
        raddr1[s] = raddr0[s];
      end else begin
        raddr1[s] = tbl_addr(fab_in.sl[s], 1);
      end
      // Operand selection
      ax[s] = fab_in.sl[s].a;
      case (op[s])
        OP_ADD: bx[s] = fab_in.sl[s].b;
        OP_ADDSUB: bx[s] = fab_in.sl[s].m[0] ? ~fab_in.sl[s].b : fab_in.sl[s].b;
        OP_UPCNT: begin
          ax[s] = st_q.q[s];
          bx[s] = 2'h0;
        end
        OP_DNCNT: begin
          ax[s] = st_q.q[s];
          bx[s] = 2'h3;
        end
        OP_MULT: bx[s] = fab_in.sl[s].b & {2{fab_in.sl[s].m[0]}};
        default: bx[s] = ~fab_in.sl[s].b;
      endcase
      sum[s] = add2(ax[s], bx[s], carry[s]);
      ne[s] = |(fab_in.sl[s].a ^ fab_in.sl[s].b);
      if (mode[s] == MODE_RIPPLE) begin
        carry[s+1] = sum[s][2];
        gen[s] = add2(ax[s], bx[s], 1'b0) >= 3'h4;
        prop[s] = &(ax[s] ^ bx[s]);
        if (op[s] == OP_CMP) begin
          fval[s] = {~(sum[s][2] & ne[s]), sum[s][2]};
          ofx[s] = ne[s];
        end else begin
          fval[s] = sum[s][1:0];
          ofx[s] = sum[s][2];
        end
      end else begin
        carry[s+1] = carry[s];
        gen[s] = 1'b0;
        prop[s] = 1'b0;
        fval[s] = rdat[s];
        // Two tables merged into a five-input function
        if (st_q.cfg[s][`CLS_CFG_FIVE_INPUT_TABLE]) begin
          ofx[s] = fab_in.sl[s].m[0] ? rdat[s][1] : rdat[s][0];
        end else begin
          ofx[s] = 1'b0;
        end
      end
      // Fabric write; companion mirrors its partner's writes
      we[s] = user & ~noram & (mode[s] == MODE_RAM) & fab_in.wre & (&fab_in.cs)
        & ((fab_in.clk ^ st_q.cfg[s][`CLS_CFG_CLKNEG])
        & ~(st_q.clk_prev ^ st_q.cfg[s][`CLS_CFG_CLKNEG]));
      if ((s % 2 == 1) && st_q.cfg[s][`CLS_CFG_DPR] && (mode[s ^ 1] != MODE_RAM)) begin
        we[s] = 1'b0;
      end
      ld[s] = wr_go & (wsel == SEL_TBL) & (st_q.awaddr[3:2] == 2'(s));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status word

  always_comb begin
    stat = '0;
    stat[`CLS_STAT_Q_LSB +: 8] = st_q.q;
    stat[`CLS_STAT_GEN_LSB +: 4] = gen;
    stat[`CLS_STAT_PROP_LSB +: 4] = prop;
    stat[`CLS_STAT_FCO] = carry[4];
    stat[`CLS_STAT_USER] = user;
  end

  ////////////////////////////////////////////////////////////////////
  // Next state: storage elements and bus slave

  always_comb begin
    st_d = st_q;
    st_d.clk_prev = fab_in.clk;
    // Storage elements
    for (int s = 0; s < 4; s++) begin
      for (int i = 0; i < 2; i++) begin
        if (!user) begin
          st_d.q[s][i] = st_q.cfg[s][`CLS_CFG_INIT0 + i];
        end else if (fab_in.lsr && !st_q.cfg[s][`CLS_CFG_LSRSYNC]) begin
          st_d.q[s][i] = st_q.cfg[s][`CLS_CFG_INIT0 + i];
        end else if (st_q.cfg[s][`CLS_CFG_LATCH0 + i]
          ? (fab_in.clk ^ st_q.cfg[s][`CLS_CFG_CLKNEG])
          : ((fab_in.clk ^ st_q.cfg[s][`CLS_CFG_CLKNEG])
          & ~(st_q.clk_prev ^ st_q.cfg[s][`CLS_CFG_CLKNEG]))) begin
          if (fab_in.lsr) begin
            st_d.q[s][i] = st_q.cfg[s][`CLS_CFG_INIT0 + i];
          end else if (fab_in.ce) begin
            st_d.q[s][i] = fval[s][i];
          end
        end
      end
    end
    // Write address and data capture
    if (axi_req.awvalid && !st_q.aw_have && !st_q.bvalid) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_q.w_have && !st_q.bvalid) begin
      st_d.w_have = 1'b1;
      st_d.wdata = axi_req.wdata;
      st_d.wstrb = axi_req.wstrb;
    end
    // Register write
    if (wr_go) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = `CLS_RESP_OKAY;
      case (wsel)
        SEL_CTRL: st_d.ctrl = 2'(merge(32'(st_q.ctrl), st_q.wdata, st_q.wstrb));
        SEL_CFG: st_d.cfg[st_q.awaddr[3:2]] = 16'(merge(32'(st_q.cfg[st_q.awaddr[3:2]]), st_q.wdata, st_q.wstrb));
        SEL_TBL: st_d.bresp = `CLS_RESP_OKAY;
        default: st_d.bresp = `CLS_RESP_SLVERR;
      endcase
    end else if (st_q.bvalid && axi_req.bready) begin
      st_d.bvalid = 1'b0;
    end
    // Register read
    if (axi_req.arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = `CLS_RESP_OKAY;
      case (rsel)
        SEL_CTRL: st_d.rdata = 32'(st_q.ctrl);
        SEL_STAT: st_d.rdata = stat;
        SEL_CFG: st_d.rdata = 32'(st_q.cfg[axi_req.araddr[3:2]]);
        SEL_TBL: st_d.rdata = tbl[axi_req.araddr[3:2]];
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = `CLS_RESP_SLVERR;
        end
      endcase
    end else if (st_q.rvalid && axi_req.rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.ctrl <= `CLS_CTRL_RST;
      for (int s = 0; s < 4; s++) begin
        st_q.cfg[s] <= `CLS_CFG_RST;
      end
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus handshakes

  always_comb begin
    axi_rsp.awready = ~st_q.aw_have & ~st_q.bvalid;
    axi_rsp.wready = ~st_q.w_have & ~st_q.bvalid;
    axi_rsp.bvalid = st_q.bvalid;
    axi_rsp.bresp = st_q.bresp;
    axi_rsp.arready = ~st_q.rvalid;
    axi_rsp.rvalid = st_q.rvalid;
    axi_rsp.rdata = st_q.rdata;
    axi_rsp.rresp = st_q.rresp;
  end

  ////////////////////////////////////////////////////////////////////
  // Fabric outputs and wide-function muxes

  assign wide6b = fab_in.sl[3].m[1] ? ofx[3] : ofx[2];

  always_comb begin
    for (int s = 0; s < 4; s++) begin
      fab_out.sl[s].f = fval[s];
      fab_out.sl[s].q = st_q.q[s];
      fab_out.sl[s].ofx = ofx[s];
    end
    fab_out.fco = carry[4];
    fab_out.cp = &prop;
    fab_out.cg = gen[3] | (prop[3] & gen[2]) | (&prop[3:2] & gen[1]) | (&prop[3:1] & gen[0]);
    fab_out.wide6 = fab_in.sl[1].m[1] ? ofx[1] : ofx[0];
    fab_out.wide7 = fab_in.sl[2].m[1] ? wide6b : fab_out.wide6;
  end

endmodule // cls_logic_block

`default_nettype wire

// ==== testbench/cls_logic_block_chk.sv ====
/*
  Checker of the logic block's bus handshakes and wide-function muxes.
  Assumes a bind onto cls_logic_block, one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cls_map.svh"

module cls_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire cls_pkg::cls_axi_req_type axi_req,
  input wire cls_pkg::cls_axi_rsp_type axi_rsp,
  input wire cls_pkg::cls_fab_in_type fab_in,
  input wire cls_pkg::cls_fab_out_type fab_out
);
  import cls_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////
  // Bus handshakes
  sequence s_wr_both;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  a_write_answer: assert property (s_wr_both |=> ##1 axi_rsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response late");
  a_bresp_held: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_aw_blocked: assert property (axi_rsp.bvalid |-> !axi_rsp.awready)
    else $error("address taken during response");
  a_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken during response");
  a_stat_refused: assert property (s_wr_both and axi_req.awaddr == `CLS_OFF_STAT |=> ##1 axi_rsp.bresp == `CLS_RESP_SLVERR)
    else $error("status write accepted");
  a_unmapped_read: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 8'h08
    |=> axi_rsp.rresp == `CLS_RESP_SLVERR && axi_rsp.rdata == 32'h0000_0000)
    else $error("unmapped read accepted");

  ////////////////////////////////////////////////////////////////////
  // Wide function selection
  a_wide6_sel: assert property (
    fab_out.wide6 == (fab_in.sl[1].m[1] ? fab_out.sl[1].ofx : fab_out.sl[0].ofx))
    else $error("wide6 select wrong");
  a_wide7_sel: assert property (
    fab_out.wide7 == (fab_in.sl[2].m[1] ? (fab_in.sl[3].m[1] ? fab_out.sl[3].ofx : fab_out.sl[2].ofx)
    : fab_out.wide6))
    else $error("wide7 select wrong");

  // Main scenarios
  c_write: cover property (s_wr_both);
  c_read: cover property (axi_req.arvalid && axi_rsp.arready);
  c_carry: cover property (fab_out.fco);
endmodule // cls_chk

bind cls_logic_block cls_chk chk_u (.sys_clk(sys_clk), .rstn(rstn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .fab_in(fab_in), .fab_out(fab_out));
`default_nettype wire

// ==== testbench/tb.sv ====
/*
  Self-checking bench of the logic block: registers, tables, ripple,
  memory and storage. Assumes the bound checker and a 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cls_map.svh"

module tb;
  import cls_pkg::*;
  logic sys_clk, rstn;
  cls_axi_req_type req;
  cls_axi_rsp_type rsp;
  cls_fab_in_type fi;
  cls_fab_out_type fo;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int k, s, op;
  logic [31:0] tbl [4];
  logic [31:0] rdv;
  logic [1:0] rs;
  logic [7:0] av, bv;
  logic [8:0] e;

  cls_logic_block dut_u (.sys_clk(sys_clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp),
    .fab_in(fi), .fab_out(fo));

  // Clock and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic end_sim;
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] r);
    logic aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    @(posedge sys_clk);
    req.awaddr <= ad;
    req.awvalid <= 1'b1;
    req.wdata <= dt;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'($urandom);
    while (!b) begin
      @(posedge sys_clk);
      if (!aw && rsp.awready === 1'b1) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready === 1'b1) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid === 1'b1) begin
        if (req.bready) begin
          b = 1;
          r = rsp.bresp;
          req.bready <= 1'b0;
        end else begin
          req.bready <= 1'b1;
        end
      end
    end
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    logic a, v;
    a = 0;
    v = 0;
    @(posedge sys_clk);
    req.araddr <= ad;
    req.arvalid <= 1'b1;
    req.rready <= 1'($urandom);
    while (!v) begin
      @(posedge sys_clk);
      if (!a && rsp.arready === 1'b1) begin
        a = 1;
        req.arvalid <= 1'b0;
      end
      if (rsp.rvalid === 1'b1) begin
        if (req.rready) begin
          v = 1;
          d = rsp.rdata;
          r = rsp.rresp;
          req.rready <= 1'b0;
        end else begin
          req.rready <= 1'b1;
        end
      end
    end
  endtask

  task automatic wreg(input logic [7:0] ad, input logic [31:0] dt);
    wr(ad, dt, rs);
    chk(32'(rs), 32'(`CLS_RESP_OKAY));
  endtask

  task automatic rreg(input logic [7:0] ad, input logic [31:0] exp);
    rd(ad, rdv, rs);
    chk(rdv, exp);
    chk(32'(rs), 32'(`CLS_RESP_OKAY));
  endtask

  // Fabric clock pulse, inverse of lvl then lvl, sampled on sys_clk
  task automatic pulse(input logic lvl);
    @(posedge sys_clk);
    fi.clk <= ~lvl;
    repeat (2) @(posedge sys_clk);
    fi.clk <= lvl;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Table model lookup for slice s, table i
  function automatic logic lut(int sl, int i);
    return tbl[sl][16 * i + {fi.sl[sl].d[i], fi.sl[sl].c[i], fi.sl[sl].b[i], fi.sl[sl].a[i]}];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    req = '0;
    fi = '0;
    k = $urandom(44);
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    chk(32'($bits(fi)), 32'd53);
    chk(32'($bits(fo)), 32'd25);
    // Reset values, unmapped and read-only places
    rreg(`CLS_OFF_CTRL, 32'h0000_0000);
    for (k = 0; k < 4; k++) begin
      tbl[k] = 32'h0000_0000;
      rreg(8'(`CLS_OFF_CFG + 4 * k), 32'h0000_0000);
      rreg(8'(`CLS_OFF_TBL + 4 * k), tbl[k]);
    end
    rd(8'h08, rdv, rs);
    chk(32'(rs), 32'(`CLS_RESP_SLVERR));
    wr(`CLS_OFF_STAT, 32'hFFFF_FFFF, rs);
    chk(32'(rs), 32'(`CLS_RESP_SLVERR));
    // Logic then ROM mode, both with five-input combine
    tbl[0] = $urandom;
    wreg(`CLS_OFF_TBL, tbl[0]);
    for (op = 0; op < 2; op++) begin
      wreg(`CLS_OFF_CFG, (op == 1) ? 32'h0000_0023 : 32'h0000_0020);
      repeat (12) begin
        @(posedge sys_clk);
        for (s = 0; s < 4; s++) fi.sl[s] <= cls_slice_in_type'(10'($urandom));
        @(negedge sys_clk);
        chk(32'(fo.sl[0].f), 32'({lut(0, 1), lut(0, 0)}));
        chk(32'(fo.sl[0].ofx), 32'(fi.sl[0].m[0] ? lut(0, 1) : lut(0, 0)));
      end
    end
    // Ripple add, subtract and add/subtract across four slices
    for (op = 0; op < 3; op++) begin
      for (k = 0; k < 4; k++) wreg(8'(`CLS_OFF_CFG + 4 * k), 32'(1 + 4 * op));
      repeat (16) begin
        @(posedge sys_clk);
        for (s = 0; s < 4; s++) fi.sl[s] <= cls_slice_in_type'(10'($urandom));
        fi.fci <= (op == 1) ? 1'b1 : 1'($urandom);
        @(negedge sys_clk);
        for (s = 0; s < 4; s++) av[2 * s +: 2] = fi.sl[s].a;
        for (s = 0; s < 4; s++) bv[2 * s +: 2] = (op == 2 && fi.sl[s].m[0]) ? ~fi.sl[s].b : fi.sl[s].b;
        e = (op == 1) ? 9'(av) + {1'b0, ~bv} + 9'd1 : 9'(av) + 9'(bv) + 9'(fi.fci);
        chk(32'({fo.sl[3].f, fo.sl[2].f, fo.sl[1].f, fo.sl[0].f}), 32'(e[7:0]));
        chk(32'(fo.fco), 32'(e[8]));
      end
    end
    // Compare in slice 0
    wreg(`CLS_OFF_CFG, 32'h0000_0019);
    repeat (12) begin
      @(posedge sys_clk);
      fi.sl[0] <= cls_slice_in_type'(10'($urandom));
      fi.fci <= 1'b1;
      @(negedge sys_clk);
      chk(32'(fo.sl[0].f), 32'({fi.sl[0].a <= fi.sl[0].b, fi.sl[0].a >= fi.sl[0].b}));
      chk(32'(fo.sl[0].ofx), 32'(fi.sl[0].a != fi.sl[0].b));
    end
    // Storage: configured state, edges of both polarities, set/reset
    tbl[0] = 32'hAAAA_AAAA;
    wreg(`CLS_OFF_TBL, tbl[0]);
    wreg(`CLS_OFF_CFG, 32'h0000_0C00);
    wreg(`CLS_OFF_CTRL, 32'h0000_0001);
    rd(`CLS_OFF_STAT, rdv, rs);
    chk(rdv & 32'h0002_0003, 32'h0002_0003);
    fi.sl[0] <= 10'h100;
    fi.ce <= 1'b1;
    fi.lsr <= 1'b0;
    pulse(1'b1);
    chk(32'(fo.sl[0].q), 32'h1);
    wreg(`CLS_OFF_CFG, 32'h0000_0D00);
    fi.sl[0] <= 10'h200;
    pulse(1'b0);
    chk(32'(fo.sl[0].q), 32'h2);
    @(posedge sys_clk);
    fi.lsr <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(32'(fo.sl[0].q), 32'h3);
    wreg(`CLS_OFF_CFG, 32'h0000_0E00);
    fi.lsr <= 1'b0;
    fi.sl[0] <= 10'h000;
    pulse(1'b1);
    @(posedge sys_clk);
    fi.lsr <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(32'(fo.sl[0].q), 32'h0);
    pulse(1'b1);
    chk(32'(fo.sl[0].q), 32'h3);
    @(posedge sys_clk);
    fi.lsr <= 1'b0;
    // Distributed memory writes and reads
    wreg(`CLS_OFF_CFG, 32'h0000_0002);
    fi.cs <= 2'b11;
    for (k = 0; k < 6; k++) begin
      fi.wre <= 1'b1;
      if (k == 5) wreg(`CLS_OFF_CTRL, 32'h0000_0003);
      fi.wad <= 4'($urandom);
      fi.wd <= 2'($urandom);
      pulse(1'b1);
      if (k < 5) tbl[0][fi.wad] = fi.wd[0];
      if (k < 5) tbl[0][16 + fi.wad] = fi.wd[1];
      @(posedge sys_clk);
      fi.sl[0] <= cls_slice_in_type'({1'b0, fi.wad[0], 1'b0, fi.wad[1], 1'b0, fi.wad[2], 1'b0, fi.wad[3], 2'b00});
      @(negedge sys_clk);
      chk(32'(fo.sl[0].f), 32'({tbl[0][16 + fi.wad], tbl[0][fi.wad]}));
      rreg(`CLS_OFF_TBL, tbl[0]);
    end
    end_sim();
  end
endmodule // tb
`default_nettype wire
